// file: logic/mem_xfer_pkg.sv
package mem_xfer_pkg;

    // opcodes of the memory-transfer group
    localparam logic [7:0] OP_LD_IND = 8'hC3;
    localparam logic [7:0] OP_ST_IND = 8'hD3;
    localparam logic [7:0] OP_LD_SHORT = 8'hE7;
    localparam logic [7:0] OP_ST_SHORT = 8'hF7;
    localparam logic [7:0] OP_LD_LONG = 8'hA7;
    localparam logic [7:0] OP_ST_LONG = 8'hB7;
    localparam logic [7:0] OP_LD_DEC = 8'hE2;
    localparam logic [7:0] OP_LD_INC = 8'hE3;

    // execution length in core cycles
    localparam logic [4:0] CYC_IND = 5'h0A;
    localparam logic [4:0] CYC_SHORT = 5'h0C;
    localparam logic [4:0] CYC_LONG = 5'h0E;
    localparam logic [4:0] CYC_STEP = 5'h01;

    // pair field 0000/0001 under the long opcodes means absolute address
    localparam logic [2:0] DIRECT_PAIR_HI = 3'h0;
    localparam logic [15:0] PAIR_ONE = 16'h0001;

    typedef enum logic [1:0] {MODE_IND, MODE_SHORT, MODE_LONG, MODE_DIRECT} addr_mode_t;
    typedef enum logic [1:0] {STEP_NONE, STEP_DEC, STEP_INC} step_t;
    typedef enum logic [3:0] {
        S_IDLE, S_RD_HI, S_RD_LO, S_RD_SRC, S_MEM_ISSUE, S_MEM_HOLD,
        S_MEM_DATA, S_UPD_LO, S_UPD_HI, S_WAIT, S_DONE
    } seq_state_t;

    typedef struct packed {
        logic [7:0] opcode;
        logic [7:0] regs;
        logic [7:0] ext1;
        logic [7:0] ext2;
    } insn_t;

    typedef struct packed {
        logic req;
        logic write;
        logic progSpace;
        logic [15:0] addr;
        logic [7:0] wrData;
    } mem_req_t;

    typedef struct packed {
        logic en;
        logic [3:0] addr;
        logic [7:0] data;
    } rf_wr_t;

endpackage

// file: logic/pair_step.sv
`timescale 1ns/1ps
`default_nettype none

// whole 16-bit step so carry and borrow cross from odd into even register
module pair_step
    import mem_xfer_pkg::*;
(
    input wire logic [15:0] pairValue,
    input wire logic countDown,
    output logic [15:0] stepped
);

    assign stepped = countDown ? pairValue - PAIR_ONE : pairValue + PAIR_ONE;

endmodule

`default_nettype wire

// file: logic/mem_xfer_exec.sv
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Opcode C3 loads a register from the address in a pair and D3 stores one there, two bytes in 10 cycles.
// - Opcodes E7 and F7 add a one-byte displacement to the pair, three bytes in 12 cycles.
// - Opcodes A7 and B7 add a two-byte offset, low byte first, to the pair, four bytes in 14 cycles.
// - Under A7 and B7 a pair field of 0000 or 0001 means a two-byte absolute address in 14 cycles.
// - In the absolute form field 0000 goes to program memory and 0001 to data memory.
// - For pair-addressed forms an even pair field selects program memory and an odd one data memory.
// - Opcode E2 reads memory into the register first and only then decrements the pair, 10 cycles.
// - Opcode E3 reads memory into the register first and only then increments the pair, 10 cycles.
// - No flag changes, the source stays intact and the pair changes only by the auto step.
// - A masked-ROM device refuses all of these instructions.
module mem_xfer_exec
    import mem_xfer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic insnValid,
    input wire insn_t insn,
    input wire logic romMaskedPin,
    input wire logic [7:0] rfRdData,
    input wire logic [7:0] memRdData,
    output logic busy,
    output logic done,
    output logic unsupported,
    output logic [3:0] rfRdAddr,
    output rf_wr_t rfWr,
    output mem_req_t memOut
);

    typedef struct packed {
        seq_state_t state;
        logic [4:0] cnt;
        logic [4:0] len;
        addr_mode_t mode;
        step_t step;
        logic isStore;
        logic [3:0] regNum;
        logic [3:0] pair;
        logic [7:0] ext1;
        logic [7:0] ext2;
        logic [7:0] hi;
        logic [7:0] lo;
        logic romSync1;
        logic romSync2;
        logic busy;
        logic done;
        logic unsupported;
        logic [3:0] rfRdAddr;
        rf_wr_t rfWr;
        mem_req_t mem;
    } exec_state_t;

    exec_state_t r;
    exec_state_t next_r;

    logic isLong;
    logic isShort;
    logic known;
    logic accept;
    logic decStore;
    addr_mode_t decMode;
    step_t decStep;
    logic [4:0] decLen;
    logic [15:0] pairValue;
    logic [15:0] stepped;
    logic [15:0] effAddr;
    logic [15:0] insnAbs;
    logic pairOdd;

    assign isLong = insn.opcode == OP_LD_LONG || insn.opcode == OP_ST_LONG;
    assign isShort = insn.opcode == OP_LD_SHORT || insn.opcode == OP_ST_SHORT;
    assign known = isLong || isShort || insn.opcode == OP_LD_IND || insn.opcode == OP_ST_IND
        || insn.opcode == OP_LD_DEC || insn.opcode == OP_LD_INC;
    assign decStore = insn.opcode == OP_ST_IND || insn.opcode == OP_ST_SHORT || insn.opcode == OP_ST_LONG;
    // pair 0-1 never serves as a long base; it flags an absolute address
    assign decMode = isLong ? ((insn.regs[3:1] == DIRECT_PAIR_HI) ? MODE_DIRECT : MODE_LONG)
        : isShort ? MODE_SHORT : MODE_IND;
    assign decStep = (insn.opcode == OP_LD_DEC) ? STEP_DEC : (insn.opcode == OP_LD_INC) ? STEP_INC : STEP_NONE;
    assign decLen = isLong ? CYC_LONG : isShort ? CYC_SHORT : CYC_IND;
    assign accept = r.state == S_IDLE && insnValid && known && !r.romSync2;
    assign insnAbs = {insn.ext2, insn.ext1};
    assign pairOdd = insn.regs[0];
    assign pairValue = {r.hi, r.lo};

    pair_step u_step (
        .pairValue(pairValue),
        .countDown(r.step == STEP_DEC),
        .stepped(stepped)
    );

    // short displacement is signed so tables can be walked both ways
    always_comb begin
        case (r.mode)
            MODE_SHORT: effAddr = pairValue + {{8{r.ext1[7]}}, r.ext1};
            MODE_LONG: effAddr = pairValue + {r.ext2, r.ext1};
            MODE_DIRECT: effAddr = {r.ext2, r.ext1};
            default: effAddr = pairValue;
        endcase
    end

    always_comb begin
        next_r = r;
        next_r.romSync1 = romMaskedPin;
        next_r.romSync2 = r.romSync1;
        next_r.done = 1'b0;
        next_r.unsupported = 1'b0;
        next_r.rfWr.en = 1'b0;
        next_r.mem.req = 1'b0;
        if (r.state != S_IDLE) begin
            next_r.cnt = r.cnt + CYC_STEP;
        end
        case (r.state)
            S_IDLE: begin
                if (insnValid && (r.romSync2 || !known)) begin
                    next_r.unsupported = 1'b1;
                end else if (accept) begin
                    next_r.state = S_RD_HI;
                    next_r.busy = 1'b1;
                    next_r.cnt = CYC_STEP;
                    next_r.len = decLen;
                    next_r.mode = decMode;
                    next_r.step = decStep;
                    next_r.isStore = decStore;
                    next_r.regNum = insn.regs[7:4];
                    next_r.pair = insn.regs[3:0];
                    next_r.ext1 = insn.ext1;
                    next_r.ext2 = insn.ext2;
                    next_r.rfRdAddr = {insn.regs[3:1], 1'b0};
                end
            end
            S_RD_HI: begin
                next_r.rfRdAddr = {r.pair[3:1], 1'b1};
                next_r.state = S_RD_LO;
            end
            S_RD_LO: begin
                next_r.hi = rfRdData;
                next_r.rfRdAddr = r.regNum;
                next_r.state = S_RD_SRC;
            end
            S_RD_SRC: begin
                next_r.lo = rfRdData;
                next_r.state = S_MEM_ISSUE;
            end
            S_MEM_ISSUE: begin
                next_r.mem.req = 1'b1;
                next_r.mem.write = r.isStore;
                next_r.mem.progSpace = ~r.pair[0];
                next_r.mem.addr = effAddr;
                next_r.mem.wrData = rfRdData;
                next_r.state = S_MEM_HOLD;
            end
            S_MEM_HOLD: begin
                next_r.state = S_MEM_DATA;
            end
            S_MEM_DATA: begin
                // stores write nothing back, so source and pair stay as they were
                if (!r.isStore) begin
                    next_r.rfWr = '{en: 1'b1, addr: r.regNum, data: memRdData};
                end
                next_r.state = (r.step != STEP_NONE) ? S_UPD_LO : S_WAIT;
            end
            S_UPD_LO: begin
                next_r.rfWr = '{en: 1'b1, addr: {r.pair[3:1], 1'b1}, data: stepped[7:0]};
                next_r.state = S_UPD_HI;
            end
            S_UPD_HI: begin
                next_r.rfWr = '{en: 1'b1, addr: {r.pair[3:1], 1'b0}, data: stepped[15:8]};
                next_r.state = S_WAIT;
            end
            S_WAIT: begin
                // fixed length keeps the core's cycle budget exact
                if (r.cnt == r.len - CYC_STEP) begin
                    next_r.done = 1'b1;
                    next_r.state = S_DONE;
                end
            end
            S_DONE: begin
                next_r.busy = 1'b0;
                next_r.state = S_IDLE;
            end
            default: begin
                next_r = '0;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign busy = r.busy;
    assign done = r.done;
    assign unsupported = r.unsupported;
    assign rfRdAddr = r.rfRdAddr;
    assign rfWr = r.rfWr;
    assign memOut = r.mem;

    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    a_len_ind: assert property (
        accept && (insn.opcode == OP_LD_IND || insn.opcode == OP_ST_IND) |-> ##1 !done [*8] ##1 !done ##1 done)
        else $error("indirect form did not finish in 10 cycles");
    a_len_short: assert property (
        accept && isShort |-> ##1 !done [*8] ##4 done)
        else $error("short indexed form did not finish in 12 cycles");
    a_len_long: assert property (
        accept && isLong |-> ##14 (done && busy) ##1 !busy)
        else $error("long form did not finish in 14 cycles");
    a_direct_addr: assert property (
        accept && decMode == MODE_DIRECT |-> ##5 (memOut.req && memOut.addr == $past(insnAbs, 5)))
        else $error("absolute address not driven");
    a_direct_space: assert property (
        accept && decMode == MODE_DIRECT |-> ##5 (memOut.progSpace == !$past(pairOdd, 5)))
        else $error("absolute form went to wrong memory");
    a_pair_space: assert property (
        memOut.req |-> memOut.progSpace == !r.pair[0])
        else $error("memory space does not follow pair parity");
    a_dec_after_read: assert property (
        accept && insn.opcode == OP_LD_DEC |-> ##7 (rfWr.en && rfWr.addr == r.regNum && rfWr.data == $past(memRdData))
        ##1 (rfWr.en && rfWr.data == r.lo - 8'h01))
        else $error("decrement not after read");
    a_inc_after_read: assert property (
        accept && insn.opcode == OP_LD_INC |-> ##7 (rfWr.en && rfWr.addr == r.regNum)
        ##1 (rfWr.en && rfWr.data == r.lo + 8'h01))
        else $error("increment not after read");
    a_carry_hi: assert property (
        rfWr.en && r.state == S_WAIT && r.step == STEP_INC |-> rfWr.data == r.hi + {7'h00, r.lo == 8'hFF})
        else $error("carry into even register lost");
    a_no_side_writes: assert property (
        rfWr.en |-> (!r.isStore && rfWr.addr == r.regNum) || (r.step != STEP_NONE && rfWr.addr[3:1] == r.pair[3:1]))
        else $error("write outside destination or pair");
    a_rom_refuse: assert property (
        r.state == S_IDLE && insnValid && r.romSync2 |=> unsupported && !busy)
        else $error("masked device executed transfer");

    c_load: cover property (accept && insn.opcode == OP_LD_IND ##10 done);
    c_store: cover property (accept && decStore ##5 memOut.write);
    c_direct: cover property (accept && decMode == MODE_DIRECT);
    c_inc_carry: cover property (rfWr.en && r.step == STEP_INC && r.lo == 8'hFF && r.state == S_WAIT);

endmodule

`default_nettype wire

// file: tb/mem_partner.sv
`timescale 1ns/1ps
`default_nettype none

// register file and program/data memory on the far side of the executer
module mem_partner
    import mem_xfer_pkg::*;
(
    input wire logic sys_clk,
    input wire logic [3:0] rfRdAddr,
    input wire rf_wr_t rfWr,
    input wire mem_req_t memOut,
    output logic [7:0] rfRdData,
    output logic [7:0] memRdData
);
    logic [7:0] regs [16];

    // program and data space differ so a wrong space select shows up
    function automatic logic [7:0] mem_val(input logic prog, input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ (prog ? 8'h3C : 8'hC3);
    endfunction

    initial begin
        rfRdData = 8'h00;
        memRdData = 8'h00;
        foreach (regs[i]) regs[i] = 8'h00;
    end

    // plain always: the bench preloads regs while the executer is idle
    always @(posedge sys_clk) begin
        if (rfWr.en === 1'b1)
            regs[rfWr.addr] <= rfWr.data;
        rfRdData <= regs[rfRdAddr];
        // read data is valid one cycle only, toggled otherwise to catch late sampling
        if (memOut.req === 1'b1 && memOut.write === 1'b0)
            memRdData <= mem_val(memOut.progSpace, memOut.addr);
        else
            memRdData <= ~memRdData;
    end
endmodule

`default_nettype wire

// file: tb/test_memory_load_insn_exec.sv
`timescale 1ns/1ps
`default_nettype none

module test_memory_load_insn_exec
    import mem_xfer_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic insnValid = 1'b0;
    logic romMaskedPin = 1'b0;
    insn_t insn = '0;
    logic [7:0] rfRdData, memRdData;
    logic busy, done, unsupported;
    logic [3:0] rfRdAddr;
    rf_wr_t rfWr;
    mem_req_t memOut, lastReq;
    int errors = 0;
    int n_tests = 0;
    int reqs = 0;

    always #25 sys_clk = ~sys_clk;

    mem_xfer_exec mem_xfer_exec_inst (.sys_clk(sys_clk), .resetn(resetn), .insnValid(insnValid), .insn(insn),
        .romMaskedPin(romMaskedPin), .rfRdData(rfRdData), .memRdData(memRdData), .busy(busy), .done(done),
        .unsupported(unsupported), .rfRdAddr(rfRdAddr), .rfWr(rfWr), .memOut(memOut));
    mem_partner mem_partner_inst (.sys_clk(sys_clk), .rfRdAddr(rfRdAddr), .rfWr(rfWr), .memOut(memOut),
        .rfRdData(rfRdData), .memRdData(memRdData));

    task automatic stop_test();
        $display("errors=%0d n_tests=%0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic ck(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] mv(input logic p, input logic [15:0] a);
        return mem_partner_inst.mem_val(p, a);
    endfunction

    // offers one instruction and checks that done lands in cycle len
    task automatic exec(input logic [7:0] op, rg, e1, e2, input int len);
        int n;
        reqs = 0;
        @(posedge sys_clk);
        insnValid <= 1'b1;
        insn <= {op, rg, e1, e2};
        @(posedge sys_clk);
        insnValid <= 1'b0;
        for (n = 1; n <= 40; n++) begin
            #1;
            if (memOut.req === 1'b1) begin
                lastReq = memOut;
                reqs++;
            end
            if (done === 1'b1)
                break;
            @(posedge sys_clk);
        end
        ck(n, len);
        if (n > 40)
            stop_test();
        @(posedge sys_clk);
        #1 ck(busy, 1'b0);
    endtask

    task automatic chk_req(input logic w, p, input logic [15:0] a);
        ck(reqs, 1);
        ck(lastReq.write, w);
        ck(lastReq.progSpace, p);
        ck(lastReq.addr, a);
    endtask

    task automatic s_indirect();
        exec(OP_LD_IND, 8'h82, 8'h00, 8'h00, 10);
        chk_req(1'b0, 1'b1, 16'h0104);
        ck(mem_partner_inst.regs[8], mv(1'b1, 16'h0104));
        exec(OP_LD_IND, 8'h83, 8'h00, 8'h00, 10);
        chk_req(1'b0, 1'b0, 16'h0104);
        ck(mem_partner_inst.regs[8], mv(1'b0, 16'h0104));
        exec(OP_ST_IND, 8'h13, 8'h00, 8'h00, 10);
        chk_req(1'b1, 1'b0, 16'h0104);
        ck(lastReq.wrData, 8'h22);
        ck({mem_partner_inst.regs[1], mem_partner_inst.regs[2], mem_partner_inst.regs[3]}, 24'h220104);
    endtask

    task automatic s_short();
        exec(OP_LD_SHORT, 8'h82, 8'h01, 8'h00, 12);
        chk_req(1'b0, 1'b1, 16'h0105);
        ck(mem_partner_inst.regs[8], mv(1'b1, 16'h0105));
        exec(OP_LD_SHORT, 8'h83, 8'hFF, 8'h00, 12);
        chk_req(1'b0, 1'b0, 16'h0103);
        exec(OP_ST_SHORT, 8'h12, 8'h01, 8'h00, 12);
        chk_req(1'b1, 1'b1, 16'h0105);
    endtask

    task automatic s_long_direct();
        exec(OP_LD_LONG, 8'h84, 8'h00, 8'h10, 14);
        chk_req(1'b0, 1'b1, 16'h1104);
        ck(mem_partner_inst.regs[8], mv(1'b1, 16'h1104));
        exec(OP_ST_LONG, 8'h15, 8'h00, 8'h10, 14);
        chk_req(1'b1, 1'b0, 16'h1104);
        // pair 0-1 holds 1122, so any base addition is visible
        exec(OP_LD_LONG, 8'h80, 8'h04, 8'h11, 14);
        chk_req(1'b0, 1'b1, 16'h1104);
        exec(OP_LD_LONG, 8'h81, 8'h04, 8'h11, 14);
        chk_req(1'b0, 1'b0, 16'h1104);
        ck(mem_partner_inst.regs[8], mv(1'b0, 16'h1104));
        exec(OP_ST_LONG, 8'h10, 8'h05, 8'h11, 14);
        chk_req(1'b1, 1'b1, 16'h1105);
        exec(OP_ST_LONG, 8'h11, 8'h05, 8'h11, 14);
        chk_req(1'b1, 1'b0, 16'h1105);
    endtask

    task automatic s_step();
        mem_partner_inst.regs[6] = 8'h10;
        mem_partner_inst.regs[7] = 8'h00;
        exec(OP_LD_DEC, 8'h86, 8'h00, 8'h00, 10);
        chk_req(1'b0, 1'b1, 16'h1000);
        ck(mem_partner_inst.regs[8], mv(1'b1, 16'h1000));
        ck({mem_partner_inst.regs[6], mem_partner_inst.regs[7]}, 16'h0FFF);
        mem_partner_inst.regs[6] = 8'h10;
        mem_partner_inst.regs[7] = 8'hFF;
        exec(OP_LD_INC, 8'h87, 8'h00, 8'h00, 10);
        chk_req(1'b0, 1'b0, 16'h10FF);
        ck(mem_partner_inst.regs[8], mv(1'b0, 16'h10FF));
        ck({mem_partner_inst.regs[6], mem_partner_inst.regs[7]}, 16'h1100);
    endtask

    task automatic refuse(input logic [7:0] op);
        @(posedge sys_clk);
        insnValid <= 1'b1;
        insn <= {op, 8'h82, 16'h0000};
        @(posedge sys_clk);
        insnValid <= 1'b0;
        #1 ck({unsupported, busy}, 2'h2);
        repeat (3) @(posedge sys_clk);
    endtask

    initial begin
        repeat (16) @(posedge sys_clk);
        resetn <= 1'b1;
        #1;
        mem_partner_inst.regs[0] = 8'h11;
        mem_partner_inst.regs[1] = 8'h22;
        mem_partner_inst.regs[2] = 8'h01;
        mem_partner_inst.regs[3] = 8'h04;
        mem_partner_inst.regs[4] = 8'h01;
        mem_partner_inst.regs[5] = 8'h04;
        s_indirect();
        s_short();
        s_long_direct();
        s_step();
        refuse(8'h00);
        romMaskedPin <= 1'b1;
        repeat (4) @(posedge sys_clk);
        refuse(OP_LD_IND);
        stop_test();
    end
endmodule

`default_nettype wire
